// *** rtl/qsp_port_logic.sv ***
// qsp_port_logic.sv: read/write port logic of a two-word burst sram
// assumes: every pin is asynchronous and oversampled by clk_in; no software registers
//
// How it works
// - nibble masks sampled with each write word; unselected nibbles keep old contents.
// - eight-bit shape: mask zero gates bits 3:0, mask one bits 7:4.
// - byte lane masks gate nine-bit lanes; unwritten lanes stay unchanged.
// - each lane mask arrives with its write word; deasserted lanes are discarded.
// - shared address: read address at positive edge, write address at negative edge.
// - address width 22, 21 or 20 by shape; each address holds a word pair.
// - address ignored whenever the port select is deasserted at the positive edge that starts the access.
// - read data launched on both output clock rises, or input clocks in single mode.
// - deselected read finishes, then outputs float after next positive output clock.
// - read starts with read select low, sampled only at positive input clock rise.
// - every read returns exactly two words as a burst.
// - accesses begin at positive input clock; inputs captured on both input clocks.
// - single clock mode times read launch from the input clocks.
// - free-running complementary echo clocks follow output clock, or input clock.
// - write starts with write select low; deselected means write data ignored.
// - valid write samples one data word on each input clock rise.
`timescale 1ns/1ps
`default_nettype none
`include "qsp_defines.svh"

module qsp_port_logic #(
  parameter int DATA_W = `QSP_DATA_W,
  parameter int LANE_W = `QSP_LANE_W,
  parameter int LANES = `QSP_LANES,
  parameter int ADDR_W = `QSP_ADDR_W
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // input and output clock pins
  input wire logic k_clk_in,
  input wire logic k_clk_n_in,
  input wire logic c_clk_in,
  input wire logic c_clk_n_in,
  input wire logic single_clock_mode_in,
  // command and write pins
  input wire logic read_port_sel_n_in,
  input wire logic write_port_sel_n_in,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [DATA_W-1:0] wdata_in,
  input wire logic [LANES-1:0] byte_lane_write_n_in,
  // read data pins and echo clocks
  output logic [DATA_W-1:0] rdata_out,
  output logic rdata_oe_out,
  output logic returned_strobe_out,
  output logic returned_strobe_n_out
);
  import qsp_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // clock pins: synchronise and find rising edges
  qsp_edges_s edges;
  logic k_lvl;
  logic c_lvl;
  logic k_rise;
  logic k_n_rise;
  logic c_rise;
  logic c_n_rise;

  qsp_pin_edge u_k (.clk_in(clk_in), .rst_b_in(rst_b_in), .pin_in(k_clk_in),
    .level_out(k_lvl), .rise_out(k_rise));
  qsp_pin_edge u_k_n (.clk_in(clk_in), .rst_b_in(rst_b_in), .pin_in(k_clk_n_in),
    .level_out(), .rise_out(k_n_rise));
  qsp_pin_edge u_c (.clk_in(clk_in), .rst_b_in(rst_b_in), .pin_in(c_clk_in),
    .level_out(c_lvl), .rise_out(c_rise));
  qsp_pin_edge u_c_n (.clk_in(clk_in), .rst_b_in(rst_b_in), .pin_in(c_clk_n_in),
    .level_out(), .rise_out(c_n_rise));

  // one driver for the whole struct; bit order follows the package fields
  assign edges = {k_rise, k_n_rise, c_rise, c_n_rise};

  ////////////////////////////////////////////////////////////////////////////
  // other pins: two flops, same depth as the clock synchroniser so they line up
  logic rsel_n_m, rsel_n;
  logic wsel_n_m, wsel_n;
  logic single_m, single;
  logic [ADDR_W-1:0] addr_m, addr;
  logic [DATA_W-1:0] wdata_m, wdata;
  logic [LANES-1:0] mask_n_m, mask_n;

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      rsel_n_m <= 1'b1;
      rsel_n <= 1'b1;
      wsel_n_m <= 1'b1;
      wsel_n <= 1'b1;
      single_m <= 1'b0;
      single <= 1'b0;
      addr_m <= '0;
      addr <= '0;
      wdata_m <= '0;
      wdata <= '0;
      mask_n_m <= '1;
      mask_n <= '1;
    end else begin
      rsel_n_m <= read_port_sel_n_in;
      rsel_n <= rsel_n_m;
      wsel_n_m <= write_port_sel_n_in;
      wsel_n <= wsel_n_m;
      single_m <= single_clock_mode_in;
      single <= single_m;
      addr_m <= addr_in;
      addr <= addr_m;
      wdata_m <= wdata_in;
      wdata <= wdata_m;
      mask_n_m <= byte_lane_write_n_in;
      mask_n <= mask_n_m;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // storage: two half-arrays, one word of each pair per address
  logic [DATA_W-1:0] mem_lo [2**ADDR_W];
  logic [DATA_W-1:0] mem_hi [2**ADDR_W];

  ////////////////////////////////////////////////////////////////////////////
  // write port: first word at positive edge, second word and address at negative
  logic wr_pend, next_wr_pend;
  logic [DATA_W-1:0] wr_word0, next_wr_word0;
  logic [LANES-1:0] wr_mask0_n, next_wr_mask0_n;
  logic wr_commit;

  // a deselected write port leaves data and masks untouched
  always_comb begin
    next_wr_pend = wr_pend;
    next_wr_word0 = wr_word0;
    next_wr_mask0_n = wr_mask0_n;
    if (edges.k_rise) begin
      next_wr_pend = !wsel_n;
      if (!wsel_n) begin
        next_wr_word0 = wdata;
        next_wr_mask0_n = mask_n;
      end
    end else if (edges.k_n_rise) begin
      next_wr_pend = 1'b0;
    end
  end

  assign wr_commit = edges.k_n_rise && wr_pend && !edges.k_rise;

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      wr_pend <= 1'b0;
      wr_word0 <= '0;
      wr_mask0_n <= '1;
    end else begin
      wr_pend <= next_wr_pend;
      wr_word0 <= next_wr_word0;
      wr_mask0_n <= next_wr_mask0_n;
    end
  end

  // lane-wise write; masked lanes keep their old contents, array has no reset
  always_ff @(posedge clk_in) begin
    if (wr_commit) begin
      for (int i = 0; i < LANES; i++) begin
        if (!wr_mask0_n[i]) begin
          mem_lo[addr][i*LANE_W +: LANE_W] <= wr_word0[i*LANE_W +: LANE_W];
        end
        if (!mask_n[i]) begin
          mem_hi[addr][i*LANE_W +: LANE_W] <= wdata[i*LANE_W +: LANE_W];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read port: accept at positive input edge, launch two beats on launch edges
  qsp_rd_state_e rd_state, next_rd_state;
  logic rd_pend, next_rd_pend;
  logic [ADDR_W-1:0] rd_addr, next_rd_addr;
  logic [DATA_W-1:0] beat1, next_beat1;
  logic [DATA_W-1:0] next_rdata;
  logic next_rdata_oe;
  logic pos_launch;
  logic neg_launch;

  assign pos_launch = single ? edges.k_rise : edges.c_rise;
  assign neg_launch = single ? edges.k_n_rise : edges.c_n_rise;

  // launch consumes the old pending read before a same-edge accept refills it
  always_comb begin
    next_rd_state = rd_state;
    next_rd_pend = rd_pend;
    next_rd_addr = rd_addr;
    next_beat1 = beat1;
    next_rdata = rdata_out;
    next_rdata_oe = rdata_oe_out;
    if (pos_launch) begin
      if (rd_pend) begin
        next_rdata = mem_lo[rd_addr];
        next_beat1 = mem_hi[rd_addr];
        next_rdata_oe = 1'b1;
        next_rd_state = QSP_RD_SECOND;
        next_rd_pend = 1'b0;
      end else begin
        next_rdata_oe = 1'b0;
        next_rd_state = QSP_RD_IDLE;
      end
    end else if (neg_launch) begin
      case (rd_state)
        QSP_RD_SECOND: begin
          next_rdata = beat1;
          next_rd_state = QSP_RD_IDLE;
        end
        default: begin
          next_rd_state = QSP_RD_IDLE;
        end
      endcase
    end
    if (edges.k_rise && !rsel_n) begin
      next_rd_pend = 1'b1;
      next_rd_addr = addr;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      rd_state <= QSP_RD_IDLE;
      rd_pend <= 1'b0;
      rd_addr <= '0;
      beat1 <= '0;
      rdata_out <= '0;
      rdata_oe_out <= 1'b0;
    end else begin
      rd_state <= next_rd_state;
      rd_pend <= next_rd_pend;
      rd_addr <= next_rd_addr;
      beat1 <= next_beat1;
      rdata_out <= next_rdata;
      rdata_oe_out <= next_rdata_oe;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // echo clocks: follow the output clock, or the input clock in single mode
  logic echo_src;
  logic next_echo;

  always_comb begin
    echo_src = single ? k_lvl : c_lvl;
    next_echo = echo_src;
  end

  // free running: never gated by read or write activity
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      returned_strobe_out <= 1'b0;
      returned_strobe_n_out <= 1'b1;
    end else begin
      returned_strobe_out <= next_echo;
      returned_strobe_n_out <= ~next_echo;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  read_float_after_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    pos_launch && !rd_pend |=> !rdata_oe_out)
    else $error("read outputs still driven after idle launch edge");
  read_accept_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    edges.k_rise && !rsel_n |=> rd_pend && rd_addr == $past(addr))
    else $error("read select not accepted at positive edge");
  read_addr_hold_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    edges.k_rise && rsel_n |=> rd_addr == $past(rd_addr))
    else $error("read address taken while deselected");
  burst_two_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    pos_launch && rd_pend && !neg_launch |=> rdata_oe_out && rd_state == QSP_RD_SECOND)
    else $error("burst did not start");
  write_desel_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    edges.k_rise && wsel_n |=> !wr_pend)
    else $error("write started while deselected");
  write_done_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    wr_commit |=> !wr_pend)
    else $error("write not closed at negative edge");
  echo_pair_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    returned_strobe_out != returned_strobe_n_out)
    else $error("echo clocks not complementary");
  echo_follow_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    ##1 returned_strobe_out == $past(echo_src))
    else $error("echo clock does not follow its source");
  single_launch_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    single && !edges.k_rise && !edges.k_n_rise |=> rdata_out == $past(rdata_out))
    else $error("read data moved without input clock edge in single mode");

  read_burst_c: cover property (@(posedge clk_in) disable iff (!rst_b_in)
    rd_state == QSP_RD_SECOND && neg_launch);
  write_commit_c: cover property (@(posedge clk_in) disable iff (!rst_b_in) wr_commit);
  masked_write_c: cover property (@(posedge clk_in) disable iff (!rst_b_in)
    wr_commit && mask_n != '0);
  single_read_c: cover property (@(posedge clk_in) disable iff (!rst_b_in)
    single && pos_launch && rd_pend);

endmodule : qsp_port_logic

`default_nettype wire

// *** rtl/qsp_defines.svh ***
// qsp_defines.svh: width defaults and burst length for the burst sram port logic
// assumes: included by bare name from the package and the design files
`ifndef QSP_DEFINES_SVH
`define QSP_DEFINES_SVH

// default shape: eighteen-bit word, two nine-bit lanes, 21 address bits
`define QSP_DATA_W 18
`define QSP_LANE_W 9
`define QSP_LANES 2
`define QSP_ADDR_W 21
// address widths of the other shapes (8/9-bit: 22, 36-bit: 20)
`define QSP_ADDR_W_X8 22
`define QSP_ADDR_W_X36 20
// bursts are two words long
`define QSP_BURST_LEN 2

`endif

// *** rtl/qsp_pkg.sv ***
// qsp_pkg.sv: types shared by the burst sram port logic
// assumes: qsp_defines.svh sits on the include path
`include "qsp_defines.svh"

package qsp_pkg;

  // read launch state: waiting for first beat, or first beat out and second due
  typedef enum logic [0:0] {
    QSP_RD_IDLE,
    QSP_RD_SECOND
  } qsp_rd_state_e;

  // rising edges seen on the four clock pins in this cycle
  typedef struct packed {
    logic k_rise;
    logic k_n_rise;
    logic c_rise;
    logic c_n_rise;
  } qsp_edges_s;

endpackage : qsp_pkg

// *** rtl/qsp_pin_edge.sv ***
// qsp_pin_edge.sv: two-flop synchroniser plus rising edge finder for one pin
// assumes: the pin is asynchronous to clk_in and toggles slower than clk_in/2
`timescale 1ns/1ps
`default_nettype none

module qsp_pin_edge (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // pin
  input wire logic pin_in,
  // results
  output logic level_out,
  output logic rise_out
);

  logic meta;
  logic sync;
  logic prev;
  logic next_meta;
  logic next_sync;
  logic next_prev;

  // meta feeds only sync, so no logic sees a metastable value
  always_comb begin
    next_meta = pin_in;
    next_sync = meta;
    next_prev = sync;
  end

  // the two sync flops keep sampling in reset, so the pin level is known at release;
  // prev is parked high in reset so a pin already high is not taken for a fresh rise
  always_ff @(posedge clk_in) begin
    meta <= next_meta;
    sync <= next_sync;
    if (!rst_b_in) begin
      prev <= 1'b1;
    end else begin
      prev <= next_prev;
    end
  end

  assign level_out = sync;
  assign rise_out = sync & ~prev;

endmodule : qsp_pin_edge

`default_nettype wire

// *** bench/qsp_ctl_model.sv ***
// qsp_ctl_model.sv: controller model driving pin clocks, selects, address and write data
// assumes: clk_in is the bench clock; the bench calls op() and wait_ph()
`timescale 1ns/1ps
`default_nettype none

module qsp_ctl_model #(
  parameter int DATA_W = 18,
  parameter int LANES = 2,
  parameter int ADDR_W = 21
) (
  // bench clock
  input wire logic clk_in,
  // pin clocks
  output logic k_out,
  output logic k_n_out,
  output logic c_out,
  output logic c_n_out,
  // command and write pins
  output logic rsel_n_out,
  output logic wsel_n_out,
  output logic [ADDR_W-1:0] addr_out,
  output logic [DATA_W-1:0] wdata_out,
  output logic [LANES-1:0] mask_n_out
);
  logic [3:0] ph = 4'h0;
  // counts phase waits that ran out; the bench reads it as a failure
  int lost = 0;

  ////////////////////////////////////////////////////////////
  // pin clocks: 16 clk period, free running; c lags k so capture comes before launch
  always @(posedge clk_in) begin
    ph <= ph + 4'h1;
  end
  assign k_out = (ph < 4'h8);
  assign k_n_out = ~k_out;
  assign c_out = (ph >= 4'h4) && (ph < 4'hC);
  assign c_n_out = ~c_out;

  // idle pins: both ports deselected
  initial begin
    rsel_n_out = 1'b1;
    wsel_n_out = 1'b1;
    addr_out = '0;
    wdata_out = '0;
    mask_n_out = '1;
  end

  ////////////////////////////////////////////////////////////
  // returns at the edge that ends phase p; bounded since ph always wraps
  task automatic wait_ph(input logic [3:0] p);
    int n;
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (ph != p && n < 40);
    if (ph != p) lost++;
  endtask : wait_ph

  // one K cycle: read address and word0 at K rise, write address and word1 at K_n rise
  task automatic op(input logic rd, input logic [ADDR_W-1:0] ra, input logic wr,
    input logic [ADDR_W-1:0] wa, input logic [DATA_W-1:0] w0, w1,
    input logic [LANES-1:0] m0, m1);
    wait_ph(4'hB);
    rsel_n_out <= ~rd;
    wsel_n_out <= ~wr;
    addr_out <= ra;
    wdata_out <= w0;
    mask_n_out <= m0;
    wait_ph(4'h3);
    rsel_n_out <= 1'b1;
    wsel_n_out <= 1'b1;
    addr_out <= wa;
    wdata_out <= w1;
    mask_n_out <= m1;
    // hold time over: released lines must not keep showing the last word
    wait_ph(4'hA);
    addr_out <= ~addr_out;
    wdata_out <= ~wdata_out;
    mask_n_out <= ~mask_n_out;
  endtask : op
endmodule : qsp_ctl_model

`default_nettype wire

// *** bench/tb.sv ***
// tb.sv: self-checking bench for the burst sram port logic
// assumes: qsp_ctl_model drives the pins; the bench owns clock, reset and single mode
`timescale 1ns/1ps
`default_nettype none

module tb;
  localparam logic [20:0] A1 = 21'h01234;
  localparam logic [20:0] A2 = 21'h1ABCD;
  logic clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic single = 1'b0;
  logic k, k_n, c, c_n, rs_n, ws_n, oe, st, st_n;
  logic [20:0] a;
  logic [17:0] wd, rd;
  logic [1:0] m_n;
  int n_fail = 0;
  int check_count = 0;

  always #2.5 clk_in = ~clk_in;

  qsp_port_logic qsp_port_logic_i (
    .clk_in(clk_in), .rst_b_in(rst_b_in), .k_clk_in(k), .k_clk_n_in(k_n),
    .c_clk_in(c), .c_clk_n_in(c_n), .single_clock_mode_in(single),
    .read_port_sel_n_in(rs_n), .write_port_sel_n_in(ws_n), .addr_in(a),
    .wdata_in(wd), .byte_lane_write_n_in(m_n), .rdata_out(rd), .rdata_oe_out(oe),
    .returned_strobe_out(st), .returned_strobe_n_out(st_n)
  );

  qsp_ctl_model qsp_ctl_model_i (
    .clk_in(clk_in), .k_out(k), .k_n_out(k_n), .c_out(c), .c_n_out(c_n),
    .rsel_n_out(rs_n), .wsel_n_out(ws_n), .addr_out(a), .wdata_out(wd), .mask_n_out(m_n)
  );

  ////////////////////////////////////////////////////////////
  // compare and verdict
  task automatic chk(input logic [17:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic test_done();
    if (qsp_ctl_model_i.lost != 0) n_fail++;
    $display("checks=%0d mismatches=%0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : test_done

  task automatic wp(input logic [3:0] p);
    qsp_ctl_model_i.wait_ph(p);
  endtask : wp

  // read burst; sample points sit mid-word, later in single mode (launch waits a K cycle)
  task automatic read_chk(input logic [20:0] ra, input logic [17:0] e0, e1, input logic s, fin);
    qsp_ctl_model_i.op(1'b1, ra, 1'b0, ra, 18'h00000, 18'h00000, 2'h3, 2'h3);
    if (s) wp(4'h0);
    wp(s ? 4'h8 : 4'hC);
    chk(rd, e0);
    chk(oe, 1'b1);
    wp(s ? 4'h0 : 4'h4);
    chk(rd, e1);
    if (fin) begin
      wp(s ? 4'h8 : 4'hC);
      chk(oe, 1'b0);
    end
  endtask : read_chk

  ////////////////////////////////////////////////////////////
  // full write, then read back both words of the pair
  task automatic t_basic();
    qsp_ctl_model_i.op(1'b0, A2, 1'b1, A1, 18'h2A5A5, 18'h15A5A, 2'h0, 2'h0);
    read_chk(A1, 18'h2A5A5, 18'h15A5A, 1'b0, 1'b1);
  endtask : t_basic

  // each word writes one lane; the other lane keeps its old data
  task automatic t_lane();
    qsp_ctl_model_i.op(1'b0, A2, 1'b1, A1, 18'h3FFFF, 18'h00000, 2'h2, 2'h1);
    read_chk(A1, 18'h2A5FF, 18'h0005A, 1'b0, 1'b1);
  endtask : t_lane

  // deselected ports: write data and read address are ignored
  task automatic t_desel();
    qsp_ctl_model_i.op(1'b0, A1, 1'b0, A1, 18'h00000, 18'h00000, 2'h0, 2'h0);
    wp(4'hC);
    chk(oe, 1'b0);
    read_chk(A1, 18'h2A5FF, 18'h0005A, 1'b0, 1'b1);
  endtask : t_desel

  // read and write in one cycle, then a back to back read of the new pair
  task automatic t_conc();
    qsp_ctl_model_i.op(1'b1, A1, 1'b1, A2, 18'h12345, 18'h0ABCD, 2'h0, 2'h0);
    // first word of the concurrent read of A1 stands since the C rise of this cycle
    chk(rd, 18'h2A5FF);
    read_chk(A2, 18'h12345, 18'h0ABCD, 1'b0, 1'b1);
  endtask : t_conc

  // echo pair follows the launch clock source, three clk behind the pin
  task automatic t_echo(input logic [3:0] hi, lo);
    wp(hi);
    chk(st, 1'b1);
    chk(st_n, 1'b0);
    wp(lo);
    chk(st, 1'b0);
    chk(st_n, 1'b1);
  endtask : t_echo

  ////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (6) @(posedge clk_in);
    rst_b_in <= 1'b1;
    @(posedge clk_in);
    chk(oe, 1'b0);
    chk(st_n, 1'b1);
    repeat (8) @(posedge clk_in);
    t_basic();
    t_lane();
    t_desel();
    t_conc();
    t_echo(4'hA, 4'h2);
    // mode pin passes synchronisers too: give it a full K period to settle
    single <= 1'b1;
    repeat (16) @(posedge clk_in);
    t_echo(4'h6, 4'hE);
    read_chk(A2, 18'h12345, 18'h0ABCD, 1'b1, 1'b1);
    test_done();
  end

  // hang guard; a phase wait that ran out ends the run at once
  initial begin
    for (int i = 0; i < 5000; i++) begin
      @(posedge clk_in);
      if (qsp_ctl_model_i.lost != 0) break;
    end
    n_fail++;
    test_done();
  end
endmodule : tb

`default_nettype wire
